// ===== hdl/rx_handoff_pkg.sv
// Purpose: Shared constants and carriers for the receive data handoff
// Assumes: 8-bit characters, single system clock
// Notes:   No software-visible registers; all control travels on ports
package rx_handoff_pkg;

    localparam int          DATA_W        = 8;
    localparam logic [7:0]  DATA_RESET    = 8'h00;
    localparam logic        FLAG_RESET    = 1'b0;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic              done;
        logic [DATA_W-1:0] data;
    } rx_frame_s;

    typedef struct packed {
        logic              receive_full_flag;
        logic              overrun;
    } rx_status_s;

endpackage : rx_handoff_pkg

// ===== hdl/rx_data_hold.sv
// Purpose: Receive data register with registered read port
// Assumes: Load and read on the same clock as the owner
// Notes:   A load shows on hold_data only from the cycle after it
module rx_data_hold (
    input  wire logic                               mclk,
    input  wire logic                               rstn,
    input  wire logic                               load,
    input  wire logic [rx_handoff_pkg::DATA_W-1:0]  load_data,
    output logic      [rx_handoff_pkg::DATA_W-1:0]  hold_data
);

    logic [rx_handoff_pkg::DATA_W-1:0] data_reg;
    logic [rx_handoff_pkg::DATA_W-1:0] data_next;

    always_comb begin
        data_next = data_reg;
        if (load) begin
            data_next = load_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            data_reg <= rx_handoff_pkg::DATA_RESET;
        end else begin
            data_reg <= data_next;
        end
    end

    assign hold_data = data_reg;

endmodule : rx_data_hold

// ===== hdl/serial_receive_data_handoff.sv
// Purpose: Hands received characters from the serial unit to software
// Assumes: frame_in comes from receive logic on mclk; rd_strobe from the reader
// Notes:   Read data is presented one cycle after rd_strobe
//          A read that meets a frame end returns the new character
//          Overrun stays set until the next read
module serial_receive_data_handoff (
    input  wire logic                               mclk,
    input  wire logic                               rstn,
    input  rx_handoff_pkg::rx_frame_s               frame_in,
    input  wire logic                               rd_strobe,
    output logic      [rx_handoff_pkg::DATA_W-1:0]  rd_data,
    output logic                                    rd_valid,
    output rx_handoff_pkg::rx_status_s              status,
    output logic                                    overrun_pulse
);

    // ****************************************************************
    // Flag state
    // ****************************************************************
    logic                                    full_reg;
    logic                                    full_next;
    logic                                    ovr_reg;
    logic                                    ovr_next;
    logic                                    ovr_pulse_reg;
    logic                                    ovr_pulse_next;

    // ****************************************************************
    // Read port state
    // ****************************************************************
    logic                                    valid_reg;
    logic                                    valid_next;
    logic [rx_handoff_pkg::DATA_W-1:0]       rdata_reg;
    logic [rx_handoff_pkg::DATA_W-1:0]       rdata_next;

    // ****************************************************************
    // Decode and data path signals
    // ****************************************************************
    logic                                    frame_done;
    logic [rx_handoff_pkg::DATA_W-1:0]       frame_data;
    logic                                    frame_end_normal;
    logic                                    frame_end_collide;
    logic                                    frame_end_overrun;
    logic                                    load;
    logic                                    read_new;
    logic [rx_handoff_pkg::DATA_W-1:0]       hold_data;
    logic [rx_handoff_pkg::DATA_W-1:0]       read_src;

    // ****************************************************************
    // Frame carrier
    // ****************************************************************
    always_comb begin
        frame_done = frame_in.done;
        frame_data = frame_in.data;
    end

    // ****************************************************************
    // Frame-end decode
    // ****************************************************************
    // Each completed frame is classed by the flag that it meets
    always_comb begin
        frame_end_normal  = 1'b0;
        frame_end_collide = 1'b0;
        frame_end_overrun = 1'b0;
        if (frame_done) begin
            if (!full_reg) begin
                frame_end_normal = 1'b1;
            end else if (rd_strobe) begin
                // The read frees the slot but returns the new character, so the held one is overwritten without an overrun
                frame_end_collide = 1'b1;
            end else begin
                frame_end_overrun = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Load strobe
    // ****************************************************************
    // Both accepted kinds of frame end write the receive data register
    always_comb begin
        load = frame_end_normal | frame_end_collide;
    end

    // ****************************************************************
    // Receive-full flag
    // ****************************************************************
    always_comb begin
        full_next = full_reg;
        if (rd_strobe) begin
            full_next = 1'b0;
        end
        // Set wins over the clear of a coincident read
        if (load) begin
            full_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            full_reg <= rx_handoff_pkg::FLAG_RESET;
        end else begin
            full_reg <= full_next;
        end
    end

    // ****************************************************************
    // Sticky overrun flag
    // ****************************************************************
    always_comb begin
        ovr_next = ovr_reg;
        if (rd_strobe) begin
            ovr_next = 1'b0;
        end
        // An overrun frame end never has a read beside it, so set and clear never meet
        if (frame_end_overrun) begin
            ovr_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ovr_reg <= rx_handoff_pkg::FLAG_RESET;
        end else begin
            ovr_reg <= ovr_next;
        end
    end

    // ****************************************************************
    // Overrun pulse
    // ****************************************************************
    always_comb begin
        ovr_pulse_next = frame_end_overrun;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ovr_pulse_reg <= rx_handoff_pkg::FLAG_RESET;
        end else begin
            ovr_pulse_reg <= ovr_pulse_next;
        end
    end

    // ****************************************************************
    // Receive data register
    // ****************************************************************
    rx_data_hold u_hold (
        .mclk      (mclk),
        .rstn      (rstn),
        .load      (load),
        .load_data (frame_data),
        .hold_data (hold_data)
    );

    // ****************************************************************
    // Read bypass
    // ****************************************************************
    // A read in the completion cycle must see the character landing now
    always_comb begin
        read_new = rd_strobe & load;
        read_src = read_new ? frame_data : hold_data;
    end

    // ****************************************************************
    // Read valid
    // ****************************************************************
    always_comb begin
        valid_next = rd_strobe;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            valid_reg <= rx_handoff_pkg::FLAG_RESET;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Held between reads so the reader may sample it late
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_strobe) begin
            rdata_next = read_src;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdata_reg <= rx_handoff_pkg::DATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ****************************************************************
    // Reader duties
    // ****************************************************************
    // The block cannot tell a first read from a repeat read.
    // A repeat read while the flag is clear may return the next character.
    // Nothing here stalls the link, so a late reader loses data to overrun.
    // A reader that needs a value twice keeps its own copy.

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rd_data                  = rdata_reg;
    assign rd_valid                 = valid_reg;
    assign status.receive_full_flag = full_reg;
    assign status.overrun           = ovr_reg;
    assign overrun_pulse            = ovr_pulse_reg;

endmodule : serial_receive_data_handoff

// ===== tb/rx_handoff_properties.sv
// Purpose: Timing checks on the receive data handoff ports
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Attached to the design by bind
module rx_handoff_properties (
    input wire logic                              mclk,
    input wire logic                              rstn,
    input wire rx_handoff_pkg::rx_frame_s         frame_in,
    input wire logic                              rd_strobe,
    input wire logic [rx_handoff_pkg::DATA_W-1:0] rd_data,
    input wire logic                              rd_valid,
    input wire rx_handoff_pkg::rx_status_s        status,
    input wire logic                              overrun_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_normal_end;
        frame_in.done && !status.receive_full_flag |=> status.receive_full_flag && !overrun_pulse;
    endproperty
    a_normal_end: assert property (p_normal_end) else $error("normal frame end wrong");
    property p_overrun;
        frame_in.done && status.receive_full_flag && !rd_strobe |=> overrun_pulse && status.overrun;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not signalled");
    property p_read_clears;
        rd_strobe && !frame_in.done |=> !status.receive_full_flag && !status.overrun;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear flag");
    property p_coincide;
        rd_strobe && frame_in.done |=> rd_valid && rd_data == $past(frame_in.data);
    endproperty
    a_coincide: assert property (p_coincide) else $error("coincident read data wrong");
    property p_load;
        frame_in.done && !status.receive_full_flag ##1 rd_strobe && !frame_in.done
            |=> rd_data == $past(frame_in.data, 2);
    endproperty
    a_load: assert property (p_load) else $error("loaded data wrong");
endmodule : rx_handoff_properties

bind serial_receive_data_handoff rx_handoff_properties u_props (.mclk(mclk), .rstn(rstn),
    .frame_in(frame_in), .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid),
    .status(status), .overrun_pulse(overrun_pulse));

// ===== tb/remote_tx_model.sv
// Purpose: Remote transmitter delivering one character per frame
// Assumes: Drives on the falling edge of mclk
// Notes:   Data shows its inverse outside the done cycle
module remote_tx_model (
    input  wire logic                mclk,
    output rx_handoff_pkg::rx_frame_s frame_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial frame_in = '0;
    task automatic send(input logic [7:0] d);
        @(negedge mclk) frame_in <= '{done: 1'b1, data: d};
        @(negedge mclk) frame_in <= '{done: 1'b0, data: ~d};
    endtask : send
endmodule : remote_tx_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the receive data handoff
// Assumes: Inputs change on the falling edge of mclk
// Notes:   Row loop first, then overrun and coincident read
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                       mclk = 1'b0;
    logic                       rstn = 1'b0;
    logic                       rd_strobe = 1'b0;
    rx_handoff_pkg::rx_frame_s  frame_in;
    rx_handoff_pkg::rx_status_s status;
    logic [7:0]                 rd_data;
    logic                       rd_valid;
    logic                       overrun_pulse;
    int                         miscompares = 0;
    int                         check_count = 0;
    int                         cycles = 0;
    logic [7:0]                 rows [4][2] = '{'{8'h01, 8'h01}, '{8'hff, 8'hff},
                                                '{8'h5a, 8'h5a}, '{8'ha5, 8'ha5}};
    remote_tx_model u_tx (.mclk(mclk), .frame_in(frame_in));
    serial_receive_data_handoff u_dut (.mclk(mclk), .rstn(rstn), .frame_in(frame_in),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid), .status(status),
        .overrun_pulse(overrun_pulse));
    initial forever #50 mclk = ~mclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd();
        @(negedge mclk) rd_strobe <= 1'b1;
        @(negedge mclk) rd_strobe <= 1'b0;
    endtask : rd
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 500) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        chk({6'h00, status}, 8'h00);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            u_tx.send(rows[i][0]);
            chk({6'h00, status}, 8'h02);
            rd();
            chk(rd_data, rows[i][1]);
            chk({7'h00, rd_valid}, 8'h01);
            chk({6'h00, status}, 8'h00);
        end
        $display("test rows done");
        u_tx.send(8'h11);
        u_tx.send(8'h22);
        chk({5'h00, status, overrun_pulse}, 8'h07);
        rd();
        chk(rd_data, 8'h11);
        chk({6'h00, status}, 8'h00);
        $display("test overrun done");
        fork
            u_tx.send(8'h33);
            rd();
        join
        chk(rd_data, 8'h33);
        chk({6'h00, status}, 8'h02);
        fork
            u_tx.send(8'h66);
            rd();
        join
        chk(rd_data, 8'h66);
        chk({5'h00, status, overrun_pulse}, 8'h04);
        $display("test coincident read done");
        rd();
        chk(rd_data, 8'h66);
        chk({6'h00, status}, 8'h00);
        fork
            u_tx.send(8'h77);
            begin
                @(negedge mclk);
                rd();
            end
        join
        chk(rd_data, 8'h77);
        chk({6'h00, status}, 8'h00);
        $display("test early read done");
        u_tx.send(8'h44);
        rstn <= 1'b0;
        repeat (2) @(negedge mclk);
        chk({4'h0, status, overrun_pulse, rd_valid}, 8'h00);
        chk(rd_data, 8'h00);
        rstn <= 1'b1;
        u_tx.send(8'h55);
        rd();
        chk(rd_data, 8'h55);
        chk({6'h00, status}, 8'h00);
        $display("test reset done");
        report_and_stop();
    end
endmodule : testbench
